// file: awd_map.svh
`ifndef AWD_MAP_SVH
`define AWD_MAP_SVH

// Byte offsets in the 16-bit-address register space.
`define AWD_WINDOW_OFS 16'h000E
`define AWD_LWORD_OFS 16'h000C
`define AWD_LWORD_SHIFT 2

// Byte lanes of the register on the data bus.
`define AWD_LANE_HI 1
`define AWD_LANE_LO 0

// Field positions inside the window register.
`define AWD_RSV_TOP 15
`define AWD_EN_BIT 14
`define AWD_DIR_BIT 13
`define AWD_RSV_HI 12
`define AWD_RSV_LO 11
`define AWD_SIZE_HI 10
`define AWD_SIZE_LO 8
`define AWD_BASE_HI 7
`define AWD_BASE_LO 0
`define AWD_HI_BYTE_HI 15
`define AWD_HI_BYTE_LO 8

// Constant read values of the reserved bits.
`define AWD_RSV_TOP_VAL 1'h0
`define AWD_RSV_PAIR_VAL 2'h3

// Hard reset values of the stored fields.
`define AWD_EN_RST 1'h0
`define AWD_DIR_RST 1'h0
`define AWD_SIZE_RST 3'h0
`define AWD_BASE_RST 8'h00

// Address lines compared against the base field.
`define AWD_ADDR_HI 23
`define AWD_ADDR_LO 16

// Range arithmetic: unit is 65536 addresses, scaled by 2^(8 - size).
`define AWD_SPAN_UNIT 25'h0010000
`define AWD_SIZE_FULL 4'h8
`define AWD_MASK_ALL 8'hFF

`endif

// file: awd_pkg.sv
package awd_pkg;

  typedef logic [2:0] awd_size_t;
  typedef logic [7:0] awd_base_t;
  typedef logic [23:0] awd_addr_t;
  typedef logic [15:0] awd_reg_t;
  typedef logic [24:0] awd_span_t;

  // Where a cycle seen on a bus is sent.
  typedef enum logic [1:0]
  {
    AWD_ROUTE_NONE,
    AWD_ROUTE_OWN,
    AWD_ROUTE_CROSS
  } awd_route_e;

endpackage

// file: awd_sync2.sv
`timescale 1ns/1ps

module awd_sync2 #(
  parameter int WIDTH = 26
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // The first stage feeds the second stage only.
  always_comb
  begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;

endmodule

// file: awd_decoder.sv
// How it works
// - Window register at offset E, byte accessible.
// - Enable bit 14 gates all A24 mapping.
// - Hard reset clears fields; soft reset keeps them.
// - Direction bit 13 picks inward or outward range.
// - Addresses outside range map the opposite way.
// - Bit 15 reads zero, writes ignored.
// - Bits 12-11 read binary 11, writes ignored.
// - Size field sets how many base bits compare.
// - Range holds 65536 times 2^(8-size) addresses.
// - Base bits compare against address lines 23-16.
// - New setting takes effect on lower-byte write.
// - Own base decoder wins over the window.
// - Compatibility mode disables the window; its alternate layout is not built.
// - Long access: this register on bits 15-0.
`timescale 1ns/1ps
`include "awd_map.svh"

module awd_decoder
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_soft_rst,
  input wire logic i_compat_layout_mode,
  input wire logic i_reg_req,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_addr,
  input wire logic [3:0] i_reg_be,
  input wire logic [31:0] i_reg_wdata,
  output logic o_reg_ack,
  output logic [31:0] o_reg_rdata,
  input wire logic i_vme_cyc,
  input wire logic [23:0] i_vme_addr,
  input wire logic i_vme_own_hit,
  input wire logic i_ext_cyc,
  input wire logic [23:0] i_ext_addr,
  input wire logic i_ext_own_hit,
  output logic o_map_outward,
  output logic o_map_inward,
  output logic o_vme_own,
  output logic o_ext_own,
  output logic o_window_active,
  output logic [24:0] o_window_span
);

  // True when the top size bits of the address equal those of the base.
  function automatic logic in_window(
    input awd_pkg::awd_addr_t addr,
    input awd_pkg::awd_base_t base,
    input awd_pkg::awd_size_t size
  );
    awd_pkg::awd_base_t mask;
    awd_pkg::awd_base_t top;
    mask = ~(`AWD_MASK_ALL >> size);
    top = addr[`AWD_ADDR_HI:`AWD_ADDR_LO];
    in_window = ((top ^ base) & mask) == 8'h00;
  endfunction

  // Routing of one bus's cycle: own decoder first, then the window.
  function automatic awd_pkg::awd_route_e route_of(
    input logic cyc,
    input logic own_hit,
    input logic live,
    input logic in_range,
    input logic range_is_this_way
  );
    if (!cyc)
    begin
      route_of = awd_pkg::AWD_ROUTE_NONE;
    end
    else if (own_hit)
    begin
      route_of = awd_pkg::AWD_ROUTE_OWN;
    end
    else if (live && (in_range == range_is_this_way))
    begin
      route_of = awd_pkg::AWD_ROUTE_CROSS;
    end
    else
    begin
      route_of = awd_pkg::AWD_ROUTE_NONE;
    end
  endfunction

  // Live window fields.
  logic en_r;
  logic en_nxt;
  logic dir_r;
  logic dir_nxt;
  awd_pkg::awd_size_t size_r;
  awd_pkg::awd_size_t size_nxt;
  awd_pkg::awd_base_t base_r;
  awd_pkg::awd_base_t base_nxt;
  // Upper byte held until the lower byte arrives.
  logic [7:0] stage_hi_r;
  logic [7:0] stage_hi_nxt;

  // Register bus answer.
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Decode results.
  logic outward_r;
  logic outward_nxt;
  logic inward_r;
  logic inward_nxt;
  logic vme_own_r;
  logic vme_own_nxt;
  logic ext_own_r;
  logic ext_own_nxt;
  awd_pkg::awd_span_t span_r;
  awd_pkg::awd_span_t span_nxt;

  // Synchronised bus inputs.
  logic [25:0] vme_sync;
  logic [25:0] ext_sync;
  logic vme_cyc_s;
  logic ext_cyc_s;
  logic vme_own_s;
  logic ext_own_s;
  awd_pkg::awd_addr_t vme_addr_s;
  awd_pkg::awd_addr_t ext_addr_s;

  logic reg_hit;
  logic wr_hi;
  logic wr_lo;
  logic [7:0] new_hi;
  awd_pkg::awd_reg_t view;
  logic live;
  logic vme_in;
  logic ext_in;
  awd_pkg::awd_route_e vme_route;
  awd_pkg::awd_route_e ext_route;

  // Backplane and cable inputs arrive from outside this clock domain.
  awd_sync2 #(
    .WIDTH(26)
  ) u_vme_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_vme_cyc, i_vme_own_hit, i_vme_addr}),
    .o_sync(vme_sync)
  );

  awd_sync2 #(
    .WIDTH(26)
  ) u_ext_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_ext_cyc, i_ext_own_hit, i_ext_addr}),
    .o_sync(ext_sync)
  );

  assign vme_cyc_s = vme_sync[25];
  assign vme_own_s = vme_sync[24];
  assign vme_addr_s = vme_sync[23:0];
  assign ext_cyc_s = ext_sync[25];
  assign ext_own_s = ext_sync[24];
  assign ext_addr_s = ext_sync[23:0];

  // Register group. A 16-bit access at E and a 32-bit access at C both
  // land in the same longword; this register always rides bits 15-0.
  always_comb
  begin
    reg_hit = i_reg_req &&
      ((i_reg_addr >> `AWD_LWORD_SHIFT) ==
       (`AWD_WINDOW_OFS >> `AWD_LWORD_SHIFT));
    wr_hi = reg_hit && i_reg_wr && i_reg_be[`AWD_LANE_HI];
    wr_lo = reg_hit && i_reg_wr && i_reg_be[`AWD_LANE_LO];
    new_hi = wr_hi ? i_reg_wdata[`AWD_HI_BYTE_HI:`AWD_HI_BYTE_LO] :
      stage_hi_r;
    en_nxt = en_r;
    dir_nxt = dir_r;
    size_nxt = size_r;
    base_nxt = base_r;
    stage_hi_nxt = stage_hi_r;
    if (wr_hi)
    begin
      stage_hi_nxt = new_hi;
    end
    else if (i_soft_rst)
    begin
      // A soft reset drops a half-written upper byte, not the window.
      stage_hi_nxt = {`AWD_RSV_TOP_VAL, en_r, dir_r,
        `AWD_RSV_PAIR_VAL, size_r};
    end
    // Bits 15 and 12-11 of the staged byte are never copied out.
    if (wr_lo)
    begin
      en_nxt = new_hi[`AWD_EN_BIT - `AWD_HI_BYTE_LO];
      dir_nxt = new_hi[`AWD_DIR_BIT - `AWD_HI_BYTE_LO];
      size_nxt = new_hi[`AWD_SIZE_HI - `AWD_HI_BYTE_LO:
        `AWD_SIZE_LO - `AWD_HI_BYTE_LO];
      base_nxt = i_reg_wdata[`AWD_BASE_HI:`AWD_BASE_LO];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      en_r <= `AWD_EN_RST;
      dir_r <= `AWD_DIR_RST;
      size_r <= `AWD_SIZE_RST;
      base_r <= `AWD_BASE_RST;
      stage_hi_r <= {`AWD_RSV_TOP_VAL, `AWD_EN_RST, `AWD_DIR_RST,
        `AWD_RSV_PAIR_VAL, `AWD_SIZE_RST};
    end
    else
    begin
      en_r <= en_nxt;
      dir_r <= dir_nxt;
      size_r <= size_nxt;
      base_r <= base_nxt;
      stage_hi_r <= stage_hi_nxt;
    end
  end

  // Bus answer group. The neighbouring register on bits 31-16 is held
  // elsewhere, so those bits read as zero from this block.
  always_comb
  begin
    view = {`AWD_RSV_TOP_VAL, en_r, dir_r, `AWD_RSV_PAIR_VAL,
      size_r, base_r};
    ack_nxt = reg_hit;
    rdata_nxt = 32'h00000000;
    if (reg_hit && !i_reg_wr)
    begin
      rdata_nxt = {16'h0000, view};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ack_r <= 1'h0;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Decode group. The alternate layout of compatibility mode is not
  // built here, so in that mode the standard window maps nothing.
  always_comb
  begin
    live = en_r && !i_compat_layout_mode;
    vme_in = in_window(vme_addr_s, base_r, size_r);
    ext_in = in_window(ext_addr_s, base_r, size_r);
    // Direction set: range is inward; clear: range is outward.
    vme_route = route_of(vme_cyc_s, vme_own_s, live, vme_in,
      !dir_r);
    ext_route = route_of(ext_cyc_s, ext_own_s, live, ext_in,
      dir_r);
    outward_nxt = vme_route == awd_pkg::AWD_ROUTE_CROSS;
    inward_nxt = ext_route == awd_pkg::AWD_ROUTE_CROSS;
    vme_own_nxt = vme_route == awd_pkg::AWD_ROUTE_OWN;
    ext_own_nxt = ext_route == awd_pkg::AWD_ROUTE_OWN;
    span_nxt = `AWD_SPAN_UNIT <<
      (`AWD_SIZE_FULL - {1'h0, size_r});
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      outward_r <= 1'h0;
      inward_r <= 1'h0;
      vme_own_r <= 1'h0;
      ext_own_r <= 1'h0;
      span_r <= `AWD_SPAN_UNIT << `AWD_SIZE_FULL;
    end
    else
    begin
      outward_r <= outward_nxt;
      inward_r <= inward_nxt;
      vme_own_r <= vme_own_nxt;
      ext_own_r <= ext_own_nxt;
      span_r <= span_nxt;
    end
  end

  assign o_reg_ack = ack_r;
  assign o_reg_rdata = rdata_r;
  assign o_map_outward = outward_r;
  assign o_map_inward = inward_r;
  assign o_vme_own = vme_own_r;
  assign o_ext_own = ext_own_r;
  assign o_window_active = en_r && !i_compat_layout_mode;
  assign o_window_span = span_r;

endmodule

// file: awd_bus_agent.sv
`timescale 1ns/1ps
// Stands for the masters of one bus; idle address lines keep changing so a
// decoder that samples them outside a cycle cannot pass by luck.
module awd_bus_agent
(
  input wire logic i_clk,
  input wire logic i_cyc,
  input wire logic [23:0] i_addr,
  input wire logic i_own,
  output logic o_cyc,
  output logic [23:0] o_addr,
  output logic o_own
);
  initial o_addr = 24'h000000;
  always @(posedge i_clk)
  begin
    o_cyc <= i_cyc;
    o_own <= i_cyc & i_own;
    o_addr <= i_cyc ? i_addr : ~o_addr;
  end
endmodule

// file: awd_monitor.sv
`timescale 1ns/1ps
module awd_monitor
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_soft_rst,
  input wire logic i_compat_layout_mode,
  input wire logic i_reg_req,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_addr,
  input wire logic i_vme_cyc,
  input wire logic i_vme_own_hit,
  input wire logic o_reg_ack,
  input wire logic [31:0] o_reg_rdata,
  input wire logic o_map_outward,
  input wire logic o_map_inward,
  input wire logic o_vme_own,
  input wire logic o_ext_own,
  input wire logic o_window_active
);
  logic hit;
  assign hit = i_reg_req && i_reg_addr[15:2] == 14'h0003;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_rd_ack;
    hit && !i_reg_wr ##1 o_reg_ack;
  endsequence
  // Pipeline is two sync flops plus one decision flop.
  AST_ACK_HIT: assert property (hit |=> o_reg_ack)
    else $error("no ack after access");
  AST_ACK_MISS: assert property (!hit |=> !o_reg_ack)
    else $error("ack without access");
  AST_RD_RSV: assert property (s_rd_ack |->
    o_reg_rdata[31:15] == 17'h00000 && o_reg_rdata[12:11] == 2'h3)
    else $error("reserved bits wrong");
  AST_OFF: assert property (!o_window_active [*4] |->
    !o_map_outward && !o_map_inward)
    else $error("mapped while off");
  AST_OWN_WINS: assert property (!(o_vme_own && o_map_outward) &&
    !(o_ext_own && o_map_inward))
    else $error("own and cross together");
  AST_OWN_CAUSE: assert property (o_vme_own |->
    $past(i_vme_own_hit, 3))
    else $error("own flag without cause");
  AST_OUT_CAUSE: assert property (o_map_outward |->
    $past(i_vme_cyc, 3) && $past(o_window_active))
    else $error("outward without cause");
  AST_SOFT: assert property ((i_soft_rst && !i_reg_req)
    ##1 $stable(i_compat_layout_mode) |-> $stable(o_window_active))
    else $error("soft reset changed window");
endmodule

bind awd_decoder awd_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst),
  .i_soft_rst(i_soft_rst), .i_compat_layout_mode(i_compat_layout_mode),
  .i_reg_req(i_reg_req), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
  .i_vme_cyc(i_vme_cyc), .i_vme_own_hit(i_vme_own_hit),
  .o_reg_ack(o_reg_ack), .o_reg_rdata(o_reg_rdata),
  .o_map_outward(o_map_outward), .o_map_inward(o_map_inward),
  .o_vme_own(o_vme_own), .o_ext_own(o_ext_own),
  .o_window_active(o_window_active));

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic srst = 1'b0;
  logic cmp = 1'b0;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic cyc = 1'b0;
  logic own = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h00000000;
  logic [23:0] a = 24'h000000;
  logic ack, mo, mi, vo, eo, vc, ec, vh, eh, act;
  logic [31:0] rd;
  logic [23:0] va, ea;
  logic [24:0] span;
  int err_total = 0;
  int comparisons = 0;
  always #20 i_clk = ~i_clk;
  awd_bus_agent vme (.i_clk(i_clk), .i_cyc(cyc), .i_addr(a), .i_own(own),
    .o_cyc(vc), .o_addr(va), .o_own(vh));
  awd_bus_agent ext (.i_clk(i_clk), .i_cyc(cyc), .i_addr(a), .i_own(own),
    .o_cyc(ec), .o_addr(ea), .o_own(eh));
  awd_decoder dut (.i_clk(i_clk), .i_rst(i_rst), .i_soft_rst(srst),
    .i_compat_layout_mode(cmp), .i_reg_req(req), .i_reg_wr(wr),
    .i_reg_addr(adr), .i_reg_be(be), .i_reg_wdata(wd), .o_reg_ack(ack),
    .o_reg_rdata(rd), .i_vme_cyc(vc), .i_vme_addr(va), .i_vme_own_hit(vh),
    .i_ext_cyc(ec), .i_ext_addr(ea), .i_ext_own_hit(eh),
    .o_map_outward(mo), .o_map_inward(mi), .o_vme_own(vo), .o_ext_own(eo),
    .o_window_active(act), .o_window_span(span));
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] ad,
    input logic [3:0] b, input logic [15:0] d, output logic [32:0] q);
    @(posedge i_clk);
    #1;
    req = 1'b1;
    wr = w;
    adr = ad;
    be = b;
    wd = {16'h0000, d};
    @(posedge i_clk);
    #1;
    req = 1'b0;
    q = {ack, rd};
  endtask
  task automatic rdc(input logic [15:0] e);
    logic [32:0] q;
    acc(1'b0, 16'h000E, 4'hF, 16'h0000, q);
    chk(q, {17'h10000, e});
  endtask
  task automatic wt(input logic [3:0] b, input logic [15:0] d);
    logic [32:0] q;
    acc(1'b1, 16'h000E, b, d, q);
    chk(q, {1'b1, 32'h00000000});
  endtask
  // Five edges: one in the agent, three in the decoder, one spare.
  task automatic probe(input logic [23:0] ad, input logic o,
    input logic [3:0] e);
    @(posedge i_clk);
    #1;
    cyc = 1'b1;
    a = ad;
    own = o;
    repeat (5) @(posedge i_clk);
    #1;
    chk({29'h0, mo, mi, vo, eo}, {29'h0, e});
    // Dropping the cycle lets idle gaps with moving address lines through.
    cyc = 1'b0;
  endtask
  task automatic t_reset();
    rdc(16'h1800);
    chk({8'h00, span}, 33'h001000000);
    chk({32'h0, act}, 33'h0);
  endtask
  task automatic t_word();
    wt(4'h3, 16'hC528);
    rdc(16'h5D28);
    chk({8'h00, span}, 33'h000080000);
    probe(24'h2FFFFF, 1'b0, 4'h8);
    probe(24'h300000, 1'b0, 4'h4);
    probe(24'h27FFFF, 1'b0, 4'h4);
    probe(24'h280000, 1'b1, 4'h3);
  endtask
  task automatic t_miss();
    logic [32:0] q;
    acc(1'b0, 16'h0010, 4'hF, 16'h0000, q);
    chk({32'h0, q[32]}, 33'h0);
    acc(1'b0, 16'h000C, 4'hF, 16'h0000, q);
    chk(q, {17'h10000, 16'h5D28});
  endtask
  task automatic t_bytes();
    wt(4'h3, 16'h0000);
    wt(4'h2, 16'h6700);
    rdc(16'h1800);
    chk({32'h0, act}, 33'h0);
    wt(4'h1, 16'h00A5);
    rdc(16'h7FA5);
    chk({8'h00, span}, 33'h000020000);
    probe(24'hA40000, 1'b0, 4'h4);
    probe(24'hA60000, 1'b0, 4'h8);
  endtask
  task automatic t_size0();
    wt(4'h3, 16'h4000);
    // The span register trails the size field by one edge.
    probe(24'hFFFFFF, 1'b0, 4'h8);
    chk({8'h00, span}, 33'h001000000);
  endtask
  task automatic t_soft();
    wt(4'h2, 16'h2700);
    @(posedge i_clk);
    #1;
    srst = 1'b1;
    @(posedge i_clk);
    #1;
    srst = 1'b0;
    wt(4'h1, 16'h0000);
    rdc(16'h5800);
    probe(24'h000000, 1'b0, 4'h8);
  endtask
  task automatic t_off();
    @(posedge i_clk);
    #1;
    cmp = 1'b1;
    probe(24'h123456, 1'b0, 4'h0);
    cmp = 1'b0;
    wt(4'h3, 16'h0000);
    probe(24'h123456, 1'b0, 4'h0);
    wt(4'h3, 16'h4000);
    @(posedge i_clk);
    #1;
    i_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    rdc(16'h1800);
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    t_reset();
    t_word();
    t_miss();
    t_bytes();
    t_size0();
    t_soft();
    t_off();
    end_sim();
  end
  initial
  begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule
